// ===== verif/gpt_timer_set_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module gpt_timer_set_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [4:0]  timer_event,
    input wire logic        adc_trigger
);
    default clocking mon_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_adc_follows_pair: assert property (adc_trigger == timer_event[2])
        else $error("adc trigger differs from pair event");
    a_event_one_cycle: assert property ((timer_event & $past(timer_event)) == 5'h00)
        else $error("timer event longer than one cycle");
    a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> !s_axi_arready ##1 s_axi_rvalid) else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid) else $error("write answer late");
    a_err_reads_zero: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0000_0000)
        else $error("refused read returned data");
endmodule
bind gpt_timer_set gpt_timer_set_monitor u_gpt_timer_set_monitor (.*);
`default_nettype wire

// ===== verif/test_gpt_timer_set.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpt_cfg.svh"
module test_gpt_timer_set
    import gpt_pkg::*;
;
    localparam gpt_reg_t ctl_r = GPT_REG_CONTROL, per_r = GPT_REG_PERIOD, cnt_r = GPT_REG_COUNT;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, idle_mode, sleep_mode;
    logic        awready, wready, bvalid, arready, rvalid, adc_trigger, gen_clk, rc_clk, sec_clk;
    logic [1:0]  bresp, rresp;
    logic [4:0]  pins, timer_event;
    logic [6:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [15:0] v, lfsr_q;
    logic [15:0] mask[5] = '{16'hA376, 16'hA37A, 16'hA372, 16'hA37A, 16'hA372};
    int          divs[4] = '{1, 8, 64, 256};
    logic [35:0] expq[$];
    int          gapq[$];
    int          ev_cnt[5], ev_at[5];
    int          cyc_n, gsel, c, miscompares, cmp_count;

    gpt_timer_set u_gpt_timer_set (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .idle_mode(idle_mode), .sleep_mode(sleep_mode), .generic_ext_clock_in(gen_clk),
        .low_power_rc_oscillator(rc_clk), .secondary_oscillator(sec_clk),
        .timer_ext_clock_pin(pins), .timer_event(timer_event), .adc_trigger(adc_trigger));

    function automatic logic [6:0] ad(input int t, input gpt_reg_t r);
        return 7'(t * 16 + 4 * int'(r));
    endfunction
    function logic [15:0] lfsr();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction
    task automatic chk(input logic [35:0] e, input logic [35:0] a);
        cmp_count++;
        if (e !== a)
        begin
            miscompares++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
        expq.push_back({2'b01, r, 32'h0000_0000});
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Ready comes late on purpose so that a held response is exercised
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end
        while (!(bvalid && bready));
        bready <= 1'b0;
    endtask
    // Kind 2'b11 marks a read whose data is not compared
    task automatic rd(input logic [6:0] a, input logic [15:0] d, input logic [1:0] k = 2'b10,
                      input logic [1:0] r = 2'h0);
        expq.push_back({k, r, 16'h0000, d});
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
        end
        while (!(rvalid && rready));
        v = rdata[15:0];
        rready <= 1'b0;
    endtask
    task automatic wait_ev(input int b);
        int c0;
        c0 = ev_cnt[b];
        for (int n = 0; n < 3000 && ev_cnt[b] == c0; n++) @(posedge aclk);
    endtask
    task automatic src(input int ch);
        case (ch)
            0: sec_clk <= !sec_clk;
            1: pins[0] <= !pins[0];
            2: rc_clk <= !rc_clk;
            default: gen_clk <= !gen_clk;
        endcase
    endtask
    // Eight rising edges on one source, then time for the synchroniser to settle
    task automatic burst(input int ch);
        repeat (16)
        begin
            src(ch);
            repeat (4) @(posedge aclk);
        end
        repeat (6) @(posedge aclk);
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cyc_n++;
        if (bvalid === 1'b1 && bready) chk(expq.pop_front(), {2'b01, bresp, 32'h0000_0000});
        if (rvalid === 1'b1 && rready)
        begin
            if (expq[0][35:34] == 2'b11) expq[0] = {2'b10, expq[0][33:32], rdata};
            chk(expq.pop_front(), {2'b10, rresp, rdata});
        end
        for (int i = 0; i < 5; i++)
        begin
            if (timer_event[i] === 1'b1)
            begin
                if (i == gsel && gapq.size() > 0) chk(36'(gapq.pop_front()), 36'(cyc_n - ev_at[i]));
                ev_cnt[i]++;
                ev_at[i] = cyc_n;
            end
        end
    end
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial
    begin
        repeat (40000) @(posedge aclk);
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, idle_mode, gen_clk, rc_clk} = '0;
        {sec_clk, sleep_mode, pins, awaddr, araddr, wdata} = '0;
        lfsr_q = 16'h0002;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int t = 0; t < 5; t++)
        begin
            rd(ad(t, ctl_r), 16'h0000);
            rd(ad(t, per_r), 16'hFFFF);
            rd(ad(t, cnt_r), 16'h0000);
            wr(ad(t, ctl_r), 16'h7FFF);
            rd(ad(t, ctl_r), mask[t] & 16'h7FFF);
            wr(ad(t, ctl_r), 16'h0000);
        end
        wr(ad(4, per_r), lfsr());
        rd(ad(4, per_r), lfsr_q);
        wr(7'h0C, lfsr(), `GPT_RESP_SLVERR);
        wr(7'h52, lfsr(), `GPT_RESP_SLVERR);
        rd(7'h50, 16'h0000, 2'b10, `GPT_RESP_SLVERR);
        for (int t = 0; t < 5; t++)
        begin
            gsel = t;
            wr(ad(t, per_r), 16'h0001);
            wr(ad(t, cnt_r), 16'h0000);
            wr(ad(t, ctl_r), 16'h8000 | 16'(t % 4) << 4);
            wait_ev(t);
            gapq.push_back(4 * divs[t % 4]);
            wait_ev(t);
            wr(ad(t, ctl_r), 16'h0000);
        end
        idle_mode <= 1'b1;
        wr(ad(0, ctl_r), 16'hA000);
        c = ev_cnt[0];
        repeat (40) @(posedge aclk);
        chk(36'(c), 36'(ev_cnt[0]));
        wr(ad(0, ctl_r), 16'h8000);
        c = ev_cnt[0];
        repeat (40) @(posedge aclk);
        chk(36'h1, 36'(ev_cnt[0] > c));
        idle_mode <= 1'b0;
        wr(ad(0, per_r), 16'hFFFF);
        pins[0] <= 1'b1;
        wr(ad(0, ctl_r), 16'h8040);
        repeat (20) @(posedge aclk);
        c = ev_cnt[0];
        pins[0] <= 1'b0;
        repeat (10) @(posedge aclk);
        chk(36'(c + 1), 36'(ev_cnt[0]));
        rd(ad(0, cnt_r), 16'h0000, 2'b11);
        chk(36'h1, 36'(v != 16'h0000));
        repeat (20) @(posedge aclk);
        rd(ad(0, cnt_r), v);
        wr(ad(0, per_r), 16'h0001);
        for (int ch = 0; ch < 4; ch++)
        begin
            wr(ad(0, ctl_r), 16'h0000);
            wr(ad(0, cnt_r), 16'h0000);
            wr(ad(0, ctl_r), 16'h8002 | 16'(ch) << 8 | 16'(ch % 2) << 2);
            c = ev_cnt[0];
            burst(ch);
            chk(36'(c + 4), 36'(ev_cnt[0]));
        end
        // Sleep: the synchronised count freezes, the unsynchronised one keeps going
        sleep_mode <= 1'b1;
        c = ev_cnt[0];
        burst(3);
        chk(36'(c), 36'(ev_cnt[0]));
        wr(ad(0, ctl_r), 16'h0000);
        wr(ad(0, ctl_r), 16'h8002);
        c = ev_cnt[0];
        burst(0);
        chk(36'(c + 4), 36'(ev_cnt[0]));
        sleep_mode <= 1'b0;
        wr(ad(0, ctl_r), 16'h0000);
        // Control writes closer than one prescaled step keep the count at zero
        wr(ad(0, per_r), 16'hFFFF);
        wr(ad(0, cnt_r), 16'h0000);
        repeat (9) wr(ad(0, ctl_r), 16'h8010);
        rd(ad(0, cnt_r), 16'h0000);
        wr(ad(0, ctl_r), 16'h0000);
        // Joined pair: high control is set to a slow, running mode that must be ignored
        wr(ad(1, ctl_r), 16'h0008);
        wr(ad(1, per_r), 16'h0003);
        wr(ad(2, per_r), 16'h0000);
        wr(ad(2, ctl_r), 16'h8030);
        wr(ad(1, ctl_r), 16'h8008);
        gsel = 2;
        c = ev_cnt[1];
        wait_ev(2);
        gapq.push_back(8);
        wait_ev(2);
        chk(36'(c), 36'(ev_cnt[1]));
        wr(ad(1, ctl_r), 16'h0008);
        wr(ad(1, per_r), 16'hFFFF);
        wr(ad(2, per_r), 16'hFFFF);
        wr(ad(1, cnt_r), 16'hFFF0);
        wr(ad(2, cnt_r), 16'h0000);
        wr(ad(1, ctl_r), 16'h8008);
        repeat (100) @(posedge aclk);
        rd(ad(2, cnt_r), 16'h0001);
        chk(36'h0, 36'(gapq.size()));
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== verilog/gpt_cfg.svh
`ifndef GPT_CFG_SVH
`define GPT_CFG_SVH

`define GPT_NUM_TIMERS 5
`define GPT_NUM_EXT 8
`define GPT_ADDR_W 7
`define GPT_TMR_HI 6
`define GPT_TMR_LO 4
`define GPT_REG_HI 3
`define GPT_REG_LO 2
`define GPT_EXT_GENERIC 0
`define GPT_EXT_RC 1
`define GPT_EXT_SECONDARY 2
`define GPT_EXT_PIN_BASE 3
`define GPT_CTL_MASK_SOLO 16'hA376
`define GPT_CTL_MASK_LOW 16'hA37A
`define GPT_CTL_MASK_HIGH 16'hA372
`define GPT_CTL_RESET 16'h0000
`define GPT_PER_RESET 16'hFFFF
`define GPT_CNT_RESET 16'h0000
`define GPT_PRE_LIM_1 8'h00
`define GPT_PRE_LIM_8 8'h07
`define GPT_PRE_LIM_64 8'h3F
`define GPT_PRE_LIM_256 8'hFF
`define GPT_RESP_OKAY 2'h0
`define GPT_RESP_SLVERR 2'h2

`endif

// ===== verilog/gpt_pkg.sv
`default_nettype none
package gpt_pkg;

    typedef struct packed {
        logic       timer_run;
        logic       rsv14;
        logic       idle_halt;
        logic [2:0] rsv12;
        logic [1:0] ext_clock_choice;
        logic       rsv7;
        logic       gate_accumulate;
        logic [1:0] prescale_select;
        logic       pair_join;
        logic       ext_input_synchronise;
        logic       clock_source_select;
        logic       rsv0;
    } gpt_ctl_t;

    typedef enum logic [1:0] {
        GPT_REG_CONTROL = 2'h0,
        GPT_REG_PERIOD  = 2'h1,
        GPT_REG_COUNT   = 2'h2
    } gpt_reg_t;

endpackage
`default_nettype wire

// ===== verilog/gpt_timer_set.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpt_cfg.svh"
module gpt_timer_set
    import gpt_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [`GPT_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`GPT_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    idle_mode,
    input  wire logic                    sleep_mode,
    input  wire logic                    generic_ext_clock_in,
    input  wire logic                    low_power_rc_oscillator,
    input  wire logic                    secondary_oscillator,
    input  wire logic [4:0]              timer_ext_clock_pin,
    output logic [4:0]                   timer_event,
    output logic                         adc_trigger
);

    localparam int NT = `GPT_NUM_TIMERS;
    localparam int NE = `GPT_NUM_EXT;

    gpt_ctl_t    ctl [NT];
    logic [15:0] per [NT];
    logic [15:0] cnt [NT];
    logic [7:0]  pcnt [NT];
    logic [NT-1:0] tick;
    logic [NT-1:0] next_event;

    // Write and read channel state
    logic [`GPT_ADDR_W-1:0] aw_addr;
    logic        aw_got;
    logic [15:0] w_data;
    logic [1:0]  w_strb;
    logic        w_got;
    logic [`GPT_ADDR_W-1:0] ar_addr;
    logic        ar_got;

    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs  = s_axi_wvalid & s_axi_wready;
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire do_write = aw_got & w_got & ~s_axi_bvalid;
    wire do_read  = ar_got & ~s_axi_rvalid;

    wire next_aw_got = (aw_got | aw_hs) & ~do_write;
    wire next_w_got  = (w_got | w_hs) & ~do_write;
    wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
    wire next_ar_got = (ar_got | ar_hs) & ~do_read;
    wire next_rvalid = do_read | (s_axi_rvalid & ~s_axi_rready);

    wire [2:0] wr_tmr = aw_addr[`GPT_TMR_HI:`GPT_TMR_LO];
    wire [1:0] wr_reg = aw_addr[`GPT_REG_HI:`GPT_REG_LO];
    wire [2:0] rd_tmr = ar_addr[`GPT_TMR_HI:`GPT_TMR_LO];
    wire [1:0] rd_reg = ar_addr[`GPT_REG_HI:`GPT_REG_LO];
    wire wr_hit = (wr_tmr < 3'(NT)) && (wr_reg != 2'h3) && (aw_addr[1:0] == 2'h0);
    wire rd_hit = (rd_tmr < 3'(NT)) && (rd_reg != 2'h3) && (ar_addr[1:0] == 2'h0);
    wire [2:0] rd_idx = rd_hit ? rd_tmr : 3'h0;

    // Upper data lanes hold nothing; only lanes 0 and 1 are stored
    wire [15:0] rd_word =
        (rd_reg == GPT_REG_CONTROL) ? 16'(ctl[rd_idx]) :
        (rd_reg == GPT_REG_PERIOD)  ? per[rd_idx] : cnt[rd_idx];
    wire [31:0] next_rdata = rd_hit ? {16'h0000, rd_word} : 32'h0000_0000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            ar_got        <= 1'b0;
            aw_addr       <= '0;
            ar_addr       <= '0;
            w_data        <= 16'h0000;
            w_strb        <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `GPT_RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `GPT_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end
        else
        begin
            aw_got        <= next_aw_got;
            w_got         <= next_w_got;
            ar_got        <= next_ar_got;
            s_axi_awready <= ~next_aw_got & ~next_bvalid;
            s_axi_wready  <= ~next_w_got & ~next_bvalid;
            s_axi_arready <= ~next_ar_got & ~next_rvalid;
            s_axi_bvalid  <= next_bvalid;
            s_axi_rvalid  <= next_rvalid;
            if (aw_hs)
                aw_addr <= s_axi_awaddr;
            if (w_hs)
            begin
                w_data <= s_axi_wdata[15:0];
                w_strb <= s_axi_wstrb[1:0];
            end
            if (ar_hs)
                ar_addr <= s_axi_araddr;
            if (do_write)
                s_axi_bresp <= wr_hit ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
            if (do_read)
            begin
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= rd_hit ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
            end
        end
    end

    function automatic logic [15:0] lane_merge(input logic [15:0] old);
        lane_merge = {w_strb[1] ? w_data[15:8] : old[15:8],
                      w_strb[0] ? w_data[7:0]  : old[7:0]};
    endfunction

    // Internal clock runs at Fosc/2: one tick every second aclk edge
    logic fosc_phase;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fosc_phase <= 1'b0;
        else
            fosc_phase <= ~fosc_phase;
    end

    // External inputs: three flops, a change is taken once stages two and three agree
    wire  [NE-1:0] ext_raw = {timer_ext_clock_pin, secondary_oscillator,
                              low_power_rc_oscillator, generic_ext_clock_in};
    logic [NE-1:0] ext_s1;
    logic [NE-1:0] ext_s2;
    logic [NE-1:0] ext_s3;
    logic [NE-1:0] ext_lvl;
    logic [NE-1:0] next_ext_lvl;
    logic [NE-1:0] ext_rise;
    logic [NE-1:0] ext_fall;

    for (genvar j = 0; j < NE; j++)
    begin : g_sync
        assign next_ext_lvl[j] = (ext_s2[j] == ext_s3[j]) ? ext_s2[j] : ext_lvl[j];
        assign ext_rise[j]     = next_ext_lvl[j] & ~ext_lvl[j];
        assign ext_fall[j]     = ~next_ext_lvl[j] & ext_lvl[j];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_s1  <= '0;
            ext_s2  <= '0;
            ext_s3  <= '0;
            ext_lvl <= '0;
        end
        else
        begin
            ext_s1  <= ext_raw;
            ext_s2  <= ext_s1;
            ext_s3  <= ext_s2;
            ext_lvl <= next_ext_lvl;
        end
    end

    for (genvar i = 0; i < NT; i++)
    begin : g_tmr
        localparam bit IS_LOW  = (i == 1) || (i == 3);
        localparam bit IS_HIGH = (i == 2) || (i == 4);
        localparam int LO = IS_HIGH ? i - 1 : i;
        localparam int HI = IS_LOW ? i + 1 : i;
        localparam int PIN = `GPT_EXT_PIN_BASE + i;
        localparam logic [15:0] MASK = (i == 0) ? `GPT_CTL_MASK_SOLO :
                                       IS_LOW ? `GPT_CTL_MASK_LOW : `GPT_CTL_MASK_HIGH;

        wire sel    = do_write && wr_hit && (wr_tmr == 3'(i));
        wire ctl_wr = sel && (wr_reg == GPT_REG_CONTROL);
        wire per_wr = sel && (wr_reg == GPT_REG_PERIOD);
        wire cnt_wr = sel && (wr_reg == GPT_REG_COUNT);

        wire [15:0] next_ctl = ctl_wr ? (lane_merge(16'(ctl[i])) & MASK) : 16'(ctl[i]);
        wire [15:0] next_per = per_wr ? lane_merge(per[i]) : per[i];

        wire ext_pick =
            (ctl[i].ext_clock_choice == 2'h3) ? ext_rise[`GPT_EXT_GENERIC] :
            (ctl[i].ext_clock_choice == 2'h2) ? ext_rise[`GPT_EXT_RC] :
            (ctl[i].ext_clock_choice == 2'h1) ? ext_rise[PIN] :
                                                ext_rise[`GPT_EXT_SECONDARY];

        // only unsynchronised standalone counting survives Sleep
        wire async_cnt = (i == 0) && !ctl[i].ext_input_synchronise;
        wire ext_tick  = ext_pick && (!sleep_mode || async_cnt);

        wire int_tick = fosc_phase && !sleep_mode &&
                        (!ctl[i].gate_accumulate || ext_lvl[PIN]);

        wire src_tick = ctl[i].clock_source_select ? ext_tick : int_tick;

        wire run_ok = ctl[i].timer_run && !(idle_mode && ctl[i].idle_halt);

        wire [7:0] pre_lim =
            (ctl[i].prescale_select == 2'h3) ? `GPT_PRE_LIM_256 :
            (ctl[i].prescale_select == 2'h2) ? `GPT_PRE_LIM_64 :
            (ctl[i].prescale_select == 2'h1) ? `GPT_PRE_LIM_8 : `GPT_PRE_LIM_1;
        wire pre_step = src_tick && run_ok;
        assign tick[i] = pre_step && (pcnt[i] >= pre_lim);

        // control write while running clears prescaler
        wire [7:0] next_pcnt = (ctl_wr && ctl[i].timer_run) ? 8'h00 :
                               tick[i] ? 8'h00 :
                               pre_step ? pcnt[i] + 8'h01 : pcnt[i];

        // low control decides the pair mode
        wire joined = (IS_LOW || IS_HIGH) && ctl[LO].pair_join;
        wire step   = joined ? tick[LO] : tick[i];

        wire [31:0] full32  = {cnt[HI], cnt[LO]};
        wire [31:0] per32   = {per[HI], per[LO]};
        wire        match32 = (full32 == per32);
        wire [31:0] next32  = match32 ? 32'h0000_0000 : full32 + 32'h0000_0001;
        wire        match16 = (cnt[i] == per[i]);
        wire [15:0] next16  = match16 ? 16'h0000 : cnt[i] + 16'h0001;
        wire [15:0] half32  = IS_HIGH ? next32[31:16] : next32[15:0];

        // count update; bus writes win over a count step
        wire [15:0] next_cnt = cnt_wr ? lane_merge(cnt[i]) :
                               step ? (joined ? half32 : next16) : cnt[i];

        // gate falling edge event on the standalone timer
        wire gate_evt = (i == 0) && ctl[i].timer_run && !ctl[i].clock_source_select &&
                        ctl[i].gate_accumulate && ext_fall[PIN];

        // joined event only on the high timer
        assign next_event[i] = joined ? (IS_HIGH && tick[LO] && match32) :
                               ((tick[i] && match16) || gate_evt);

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                ctl[i]  <= gpt_ctl_t'(`GPT_CTL_RESET);
                per[i]  <= `GPT_PER_RESET;
                cnt[i]  <= `GPT_CNT_RESET;
                pcnt[i] <= 8'h00;
            end
            else
            begin
                ctl[i]  <= gpt_ctl_t'(next_ctl);
                per[i]  <= next_per;
                cnt[i]  <= next_cnt;
                pcnt[i] <= next_pcnt;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_event <= '0;
            adc_trigger <= 1'b0;
        end
        else
        begin
            timer_event <= next_event;
            // trigger from first pair high flag only
            adc_trigger <= next_event[2];
        end
    end

endmodule
`default_nettype wire
